// ==== core/flash_host_pkg.sv ====
package flash_host_pkg;

  localparam int unsigned ADDR_W = 22;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CLK_MHZ = 50;
  // access timing in ns, turned into cycle counts below (least times round up)
  localparam int unsigned SETUP_NS = 40;
  localparam int unsigned STROBE_NS = 70;
  localparam int unsigned HOLD_NS = 20;
  localparam int unsigned POWER_UP_RESET_NS = 200;
  localparam int unsigned SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned POWER_UP_RESET_CYC = (POWER_UP_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              write;
  } host_req_t;

  typedef struct packed {
    logic chip_enable_n;
    logic output_enable_n;
    logic write_enable_n;
    logic reset_n;
    logic write_protect_n;
  } flash_ctrl_t;

endpackage : flash_host_pkg

// ==== core/flash_host.sv ====
`timescale 1ns/1ps
// Overview of operation
// - drive command and data on data_pins
// - host holds reset low through power-up
// - address/data latched on first rising strobe
// - no erase/program at low program voltage; supply_ok is checked only when a write is taken
// - command address lies in target block
module flash_host (
  input  wire logic                                core_clk,        // system clock
  input  wire logic                                rst_n,           // async reset, active low
  input  wire logic                                req_valid,       // request strobe
  input  flash_host_pkg::host_req_t                req,             // address, data, direction
  input  wire logic                                device_reset_req, // hold device in reset
  input  wire logic                                lockdown_enable, // keep write protect low
  input  wire logic                                supply_ok,       // supplies above lockout levels
  output logic                                     req_ready,       // idle, may take a request
  output logic                                     resp_valid,      // one-cycle completion pulse
  output logic [flash_host_pkg::DATA_W-1:0]        resp_rdata,      // read data
  output logic                                     resp_refused,    // write refused, supply low
  output logic [flash_host_pkg::ADDR_W-1:0]        address_pins,    // device address
  output logic [flash_host_pkg::DATA_W-1:0]        data_out,        // data pin drive value
  output logic                                     data_oe_n,       // low while host drives data_pins
  input  wire logic [flash_host_pkg::DATA_W-1:0]   data_in,         // data pin level
  output flash_host_pkg::flash_ctrl_t              ctrl             // control pins
);

  typedef enum logic [2:0] {ST_PWR, ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} state_t;

  state_t                              state;
  logic [flash_host_pkg::CNT_W-1:0]    cnt;
  logic                                is_write;
  logic                                take;
  logic                                refuse;
  logic                                phase_end;
  logic                                reset_hold;
  flash_host_pkg::flash_ctrl_t         next_ctrl;

  // counter load for a phase of n cycles; a phase ends in the cycle its counter reads zero
  function automatic logic [flash_host_pkg::CNT_W-1:0] cyc(input int unsigned n);
    cyc = flash_host_pkg::CNT_W'(n - 1);
  endfunction : cyc

  // one decode of a taken request, so sequencer, latches and answer never disagree
  function automatic logic taken(input state_t s, input logic valid);
    taken = s == ST_IDLE && valid;
  endfunction : taken

  // one flag stands for both supply monitors; a write taken while it is low is refused, a write already under way goes on
  function automatic logic refused(input logic write, input logic ok);
    refused = write && !ok;
  endfunction : refused

  // the device stays selected through the hold cycle in both directions
  function automatic logic selected(input state_t s);
    selected = s == ST_SETUP || s == ST_STROBE || s == ST_HOLD;
  endfunction : selected

  // a device reset request never cuts setup or strobe; the pin still drops, so the device aborts
  function automatic logic abortable(input state_t s);
    abortable = s != ST_SETUP && s != ST_STROBE;
  endfunction : abortable

  function automatic logic strobe_end(input state_t s, input logic done);
    strobe_end = s == ST_STROBE && done;
  endfunction : strobe_end

  function automatic logic read_drive(input state_t s, input logic write);
    read_drive = !write && (s == ST_SETUP || s == ST_STROBE);
  endfunction : read_drive

  function automatic logic write_strobe(input state_t s, input logic write);
    write_strobe = write && s == ST_STROBE;
  endfunction : write_strobe

  localparam logic [flash_host_pkg::CNT_W-1:0] PWR_LOAD = cyc(flash_host_pkg::POWER_UP_RESET_CYC);

  assign take       = taken(state, req_valid);
  assign refuse     = refused(req.write, supply_ok);
  assign phase_end  = cnt == '0;
  assign reset_hold = device_reset_req && abortable(state);

  // phase sequence; the power-up stage holds the device in reset before any access
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_PWR;
    end else if (reset_hold) begin
      state <= ST_PWR;
    end else begin
      unique case (state)
        ST_PWR: begin
          if (phase_end) state <= ST_IDLE;
        end
        ST_IDLE: begin
          if (take && !refuse) state <= ST_SETUP;
        end
        ST_SETUP: begin
          if (phase_end) state <= ST_STROBE;
        end
        ST_STROBE: begin
          if (phase_end) state <= ST_HOLD;
        end
        ST_HOLD: begin
          if (phase_end) state <= ST_IDLE;
        end
      endcase
    end
  end

  // phase counter; out of reset it holds the power-up count, so the device reset pin stays low that long
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= PWR_LOAD;
    end else if (reset_hold) begin
      cnt <= PWR_LOAD;
    end else begin
      unique case (state)
        ST_PWR: begin
          if (!phase_end) cnt <= cnt - 1'b1;
        end
        ST_IDLE: begin
          if (take && !refuse) cnt <= cyc(flash_host_pkg::SETUP_CYC);
        end
        ST_SETUP: begin
          if (phase_end) cnt <= cyc(flash_host_pkg::STROBE_CYC);
          else cnt <= cnt - 1'b1;
        end
        ST_STROBE: begin
          if (phase_end) cnt <= cyc(flash_host_pkg::HOLD_CYC);
          else cnt <= cnt - 1'b1;
        end
        ST_HOLD: begin
          if (!phase_end) cnt <= cnt - 1'b1;
        end
      endcase
    end
  end

  // address and data latched at the take, held until after the rising strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      address_pins <= '0;
      data_out     <= '0;
      is_write     <= 1'b0;
    end else if (take) begin
      address_pins <= req.addr;
      data_out     <= req.wdata;
      is_write     <= req.write;
    end
  end

  // next pin levels; the write strobe rises a cycle before chip enable so data stays valid
  always_comb begin
    next_ctrl.reset_n         = !(state == ST_PWR || device_reset_req);
    next_ctrl.write_protect_n = !lockdown_enable;
    next_ctrl.chip_enable_n   = !selected(state);
    next_ctrl.output_enable_n = !read_drive(state, is_write);
    next_ctrl.write_enable_n  = !write_strobe(state, is_write);
  end

  // control pins come straight from flops; reset leaves the device held in reset and deselected
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '{chip_enable_n: 1'b1, output_enable_n: 1'b1, write_enable_n: 1'b1,
                reset_n: 1'b0, write_protect_n: 1'b0};
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // host drives the data pins from setup to the end of the hold cycle of a write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= !(is_write && selected(state));
    end
  end

  // ready only when idle and nothing pending; take does not wait for it, so a request held in idle is taken again
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= state == ST_IDLE && !req_valid && !device_reset_req;
    end
  end

  // completion pulse; a refused write answers at once and leaves the control pins idle, though address_pins still take its address
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid   <= 1'b0;
      resp_refused <= 1'b0;
    end else begin
      resp_valid   <= (take && refuse) || strobe_end(state, phase_end);
      resp_refused <= take && refuse;
    end
  end

  // read data sampled at the end of the strobe, while the device still drives the pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_rdata <= '0;
    end else if (strobe_end(state, phase_end) && !is_write) begin
      resp_rdata <= data_in;
    end
  end

endmodule : flash_host

// ==== tb/flash_dev_model.sv ====
`timescale 1ns/1ps
module flash_dev_model (
  input  wire logic [21:0]            a,   // address
  input  wire logic [15:0]            d,   // pin level
  input  flash_host_pkg::flash_ctrl_t c,   // control
  output logic                        drv, // drives pins
  output logic [15:0]                 q    // read word
);
  logic [15:0] mem [logic [21:0]];
  assign drv = !c.chip_enable_n && !c.output_enable_n && c.write_enable_n && c.reset_n;
  // re-evaluated on every control change too, since a store into the array raises no event
  always @(a, c) q = mem.exists(a) ? mem[a] : 16'hFFFF;
  // first strobe to rise latches one word, nothing queued
  always @(posedge c.write_enable_n or posedge c.chip_enable_n)
    if (c.reset_n && !(c.write_enable_n && c.chip_enable_n)) mem[a] = d;
endmodule : flash_dev_model

// ==== tb/flash_host_properties.sv ====
`timescale 1ns/1ps
module flash_host_properties (
  input wire logic core_clk, rst_n, device_reset_req,  // clock, reset, request
  input wire logic lockdown_enable, supply_ok, data_oe_n, // levels
  input wire logic [21:0]       address_pins,           // address
  input wire logic [15:0]       data_out,               // data drive
  input flash_host_pkg::flash_ctrl_t ctrl               // control
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_strobe; (!ctrl.write_enable_n) [*4]; endsequence
  sequence s_release; ctrl.write_enable_n && !ctrl.chip_enable_n ##1 ctrl.chip_enable_n; endsequence
  a_we_shape: assert property ($fell(ctrl.write_enable_n) |-> s_strobe ##1 s_release)
    else $error("write strobe shape");
  a_write_excl: assert property (!ctrl.write_enable_n |-> ctrl.output_enable_n && !ctrl.chip_enable_n)
    else $error("write without select");
  a_no_fight: assert property (!ctrl.output_enable_n |-> data_oe_n && !ctrl.chip_enable_n)
    else $error("read with host drive");
  a_held_data: assert property (!ctrl.write_enable_n |=> $stable(address_pins) && $stable(data_out) && !data_oe_n)
    else $error("data moved in write");
  a_supply_lock: assert property ($fell(ctrl.write_enable_n) |-> supply_ok)
    else $error("write at low supply");
  a_reset_req: assert property (device_reset_req |-> ##[1:12] !ctrl.reset_n)
    else $error("device reset late");
  a_power_hold: assert property ($fell(device_reset_req) |-> (!ctrl.reset_n && ctrl.chip_enable_n) [*8])
    else $error("reset released early");
  a_wp_follow: assert property (1'h1 |=> ctrl.write_protect_n == !$past(lockdown_enable))
    else $error("write protect wrong");
endmodule : flash_host_properties
bind flash_host flash_host_properties props (.*);

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 0, rst_n = 0, req_valid = 0, device_reset_req = 0, lockdown_enable = 0, supply_ok = 1;
  flash_host_pkg::host_req_t   req = '0;
  flash_host_pkg::flash_ctrl_t ctrl;
  logic        req_ready, resp_valid, resp_refused, data_oe_n, drv;
  logic [21:0] address_pins, ad [6];
  logic [15:0] resp_rdata, data_out, data_in, q, lastv, wd [6];
  logic [17:0] exp_q [$], e;
  int err_count = 0, samples_checked = 0, seed = 97744;
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk) lastv <= data_in;
  // released pins show the complement of the level sampled at the last clock edge
  assign data_in = drv ? q : !data_oe_n ? data_out : ~lastv;
  flash_host dut (.*);
  flash_dev_model dev (.a(address_pins), .d(data_in), .c(ctrl), .drv(drv), .q(q));
  task automatic chk(input string n, input logic [15:0] x, g);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // a response with nothing expected counts as a mismatch
  always @(negedge core_clk) if (resp_valid === 1'h1) begin
    if (exp_q.size() == 0) err_count++;
    else begin
      e = exp_q.pop_front();
      chk("resp_refused", 16'(e[16]), 16'(resp_refused));
      if (e[17]) chk("resp_rdata", e[15:0], resp_rdata);
    end
  end
  task automatic xfer(input logic w, input logic [21:0] a, input logic [15:0] d, input logic [17:0] x);
    int n = 0;
    while (req_ready !== 1'h1 && n++ < 300) @(posedge core_clk) #2;
    exp_q.push_back(x);
    req = '{a, d, w};
    req_valid = 1;
    do @(posedge core_clk) #2; while (resp_valid !== 1'h1 && n++ < 600);
    if (resp_valid !== 1'h1) err_count++;
    req_valid = 0;
  endtask : xfer
  initial begin
    repeat (16) @(posedge core_clk);
    #2 rst_n = 1;
    foreach (ad[i]) begin
      // distinct low bits, so no later write overwrites an earlier word
      ad[i] = {19'($random(seed)), 3'(i)};
      wd[i] = 16'($random(seed));
      xfer(1, ad[i], wd[i], 18'h0);
    end
    foreach (ad[i]) xfer(0, ad[i], 16'h0, {2'h2, wd[i]});
    supply_ok = 0;
    xfer(1, ad[0], ~wd[0], 18'h10000);
    supply_ok = 1;
    lockdown_enable = 1;
    device_reset_req = 1;
    repeat (20) @(posedge core_clk);
    #2 device_reset_req = 0;
    xfer(0, ad[0], 16'h0, {2'h2, wd[0]});
    repeat (2) @(posedge core_clk);
    tally_and_finish;
  end
  initial begin
    #400000;
    err_count++;
    tally_and_finish;
  end
  task automatic tally_and_finish;
    err_count += exp_q.size();
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
endmodule : tb_top
